// File: core/rtcp_pkg.sv
// Shared constants, types and helpers of the three-wire calendar clock port
package rtcp_pkg;

  // Timing: core clock and crystal rate; the divider runs at twice the crystal rate
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          OSC_HZ        = 32_768;
  localparam int          HALF_TICK_HZ  = 2 * OSC_HZ;
  localparam int          ACC_W         = 26;
  localparam logic [25:0] ACC_LIMIT     = 26'(CLK_HZ);
  localparam logic [25:0] ACC_STEP      = 26'(HALF_TICK_HZ);
  localparam int          SUB_W         = 16;
  localparam logic [15:0] SUB_LAST      = 16'(HALF_TICK_HZ - 1);

  // Serial framing
  localparam int          CMD_BITS      = 8;
  localparam int          DATA_BITS     = 8;
  localparam int          CNT_W         = 4;
  localparam logic [3:0]  CMD_LAST      = 4'(CMD_BITS - 1);
  localparam logic [3:0]  DATA_LAST     = 4'(DATA_BITS - 1);
  localparam logic [3:0]  DATA_DONE     = 4'(DATA_BITS);
  localparam int          CMD_RD_BIT    = 0;
  localparam int          CMD_IDX_LSB   = 1;
  localparam int          CMD_IDX_MSB   = 4;

  // Register indices carried in the command byte
  localparam logic [3:0]  REG_STATUS2   = 4'h0;
  localparam logic [3:0]  REG_YEAR      = 4'h1;
  localparam logic [3:0]  REG_MONTH     = 4'h2;
  localparam logic [3:0]  REG_DAY       = 4'h3;
  localparam logic [3:0]  REG_HOUR      = 4'h4;
  localparam logic [3:0]  REG_MINUTE    = 4'h5;
  localparam logic [3:0]  REG_SECOND    = 4'h6;
  localparam logic [3:0]  REG_ALARM1    = 4'h7;
  localparam logic [3:0]  REG_ALARM2    = 4'h8;
  localparam logic [3:0]  REG_FREQ      = 4'h9;

  // Interrupt pin source codes held in status register 2
  localparam logic [2:0]  INT_ALARM1    = 3'h0;
  localparam logic [2:0]  INT_ALARM2    = 3'h1;
  localparam logic [2:0]  INT_USER_FREQ = 3'h2;
  localparam logic [2:0]  INT_MINUTE1   = 3'h3;
  localparam logic [2:0]  INT_MINUTE2   = 3'h4;
  localparam logic [2:0]  INT_CLK32K    = 3'h5;
  localparam logic [2:0]  STATUS2_RST   = 3'h0;
  localparam logic [5:0]  ALARM1_RST    = 6'h00;
  localparam logic [4:0]  ALARM2_RST    = 5'h00;
  localparam logic [3:0]  FREQ_RST      = 4'hF;
  localparam logic [5:0]  MINUTE2_HALF  = 6'h1E;

  // Calendar limits; year counts 0..99 as 2000..2099
  localparam logic [6:0]  YEAR_MAX      = 7'h63;
  localparam logic [3:0]  MONTH_MAX     = 4'hC;
  localparam logic [4:0]  HOUR_MAX      = 5'h17;
  localparam logic [5:0]  MIN_MAX       = 6'h3B;
  localparam logic [5:0]  SEC_MAX       = 6'h3B;
  localparam logic [6:0]  YEAR_RST      = 7'h00;
  localparam logic [3:0]  MONTH_RST     = 4'h1;
  localparam logic [4:0]  DAY_RST       = 5'h01;
  localparam logic [3:0]  MON_FEB       = 4'h2;
  localparam logic [3:0]  MON_APR       = 4'h4;
  localparam logic [3:0]  MON_JUN       = 4'h6;
  localparam logic [3:0]  MON_SEP       = 4'h9;
  localparam logic [3:0]  MON_NOV       = 4'hB;
  localparam logic [4:0]  DAYS_LONG     = 5'h1F;
  localparam logic [4:0]  DAYS_SHORT    = 5'h1E;
  localparam logic [4:0]  DAYS_FEB      = 5'h1C;
  localparam logic [4:0]  DAYS_FEB_LEAP = 5'h1D;

  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } rtcp_time_t;

  typedef struct packed {
    logic       we;
    logic [3:0] idx;
    logic [7:0] data;
  } rtcp_wr_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CMD   = 4'b0010,
    ST_WDATA = 4'b0100,
    ST_RDATA = 4'b1000
  } rtcp_state_t;

  // Every year of 2000..2099 divisible by four is a leap year, 2000 included
  function automatic logic [4:0] rtcp_days_in(input logic [3:0] m, input logic [6:0] y);
    case (m)
      MON_FEB: return (y[1:0] == 2'h0) ? DAYS_FEB_LEAP : DAYS_FEB;
      MON_APR, MON_JUN, MON_SEP, MON_NOV: return DAYS_SHORT;
      default: return DAYS_LONG;
    endcase
  endfunction

endpackage

// File: core/rtcp_calendar.sv
// Binary calendar counter with leap years, advanced once per second
`timescale 1ns/100ps
`default_nettype none
module rtcp_calendar
  import rtcp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       sec_tick,
  input  wire rtcp_wr_t   wr,
  output var  rtcp_time_t now
);

  rtcp_time_t t_r;
  wire logic  sec_wrap;
  wire logic  min_wrap;
  wire logic  hour_wrap;
  wire logic  day_wrap;
  wire logic  mon_wrap;
  wire logic  year_wrap;

  assign sec_wrap  = (t_r.second == SEC_MAX);
  assign min_wrap  = (t_r.minute == MIN_MAX);
  assign hour_wrap = (t_r.hour == HOUR_MAX);
  assign day_wrap  = (t_r.day >= rtcp_days_in(t_r.month, t_r.year));
  assign mon_wrap  = (t_r.month >= MONTH_MAX);
  assign year_wrap = (t_r.year >= YEAR_MAX);
  assign now       = t_r;

  ////////////////////////////////////////////////////////////////////////////
  // A host write wins over a tick in the same cycle; the tick is dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      t_r <= '{year: YEAR_RST, month: MONTH_RST, day: DAY_RST,
               hour: '0, minute: '0, second: '0};
    end else if (wr.we) begin
      case (wr.idx)
        REG_YEAR:   t_r.year   <= wr.data[6:0];
        REG_MONTH:  t_r.month  <= wr.data[3:0];
        REG_DAY:    t_r.day    <= wr.data[4:0];
        REG_HOUR:   t_r.hour   <= wr.data[4:0];
        REG_MINUTE: t_r.minute <= wr.data[5:0];
        REG_SECOND: t_r.second <= wr.data[5:0];
        default:    t_r        <= t_r;
      endcase
    end else if (sec_tick) begin
      t_r.second <= sec_wrap ? '0 : t_r.second + 6'h01;
      if (sec_wrap) begin
        t_r.minute <= min_wrap ? '0 : t_r.minute + 6'h01;
        if (min_wrap) begin
          t_r.hour <= hour_wrap ? '0 : t_r.hour + 5'h01;
          if (hour_wrap) begin
            t_r.day <= day_wrap ? DAY_RST : t_r.day + 5'h01;
            if (day_wrap) begin
              t_r.month <= mon_wrap ? MONTH_RST : t_r.month + 4'h1;
              if (mon_wrap) begin
                t_r.year <= year_wrap ? YEAR_RST : t_r.year + 7'h01;
              end
            end
          end
        end
      end
    end
  end

endmodule // rtcp_calendar
`default_nettype wire

// File: core/rtcp_port.sv
// Three-wire host port, timebase and interrupt pin selection of the calendar clock
`timescale 1ns/100ps
`default_nettype none

module rtcp_port
  import rtcp_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic cs_pin,
  input  wire logic sck_pin,
  input  wire logic bidir_data_pin_in,
  output var  logic bidir_data_pin_out,
  output var  logic bidir_data_pin_oe,
  output var  logic int_n_out,
  output var  logic int_n_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: bit 2 chip select, bit 1 serial clock, bit 0 data
  logic [2:0]       sync1_r;
  logic [2:0]       sync2_r;
  logic             cs_d_r;
  logic             sck_d_r;
  wire logic        cs_s;
  wire logic        sck_s;
  wire logic        din_s;
  wire logic        cs_rise;
  wire logic        sck_rise;
  wire logic        sck_fall;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      cs_d_r  <= 1'b0;
      sck_d_r <= 1'b0;
    end else begin
      sync1_r <= {cs_pin, sck_pin, bidir_data_pin_in};
      sync2_r <= sync1_r;
      cs_d_r  <= sync2_r[2];
      sck_d_r <= sync2_r[1];
    end
  end

  assign cs_s     = sync2_r[2];
  assign sck_s    = sync2_r[1];
  assign din_s    = sync2_r[0];
  assign cs_rise  = cs_s & ~cs_d_r;
  assign sck_rise = cs_s & sck_s & ~sck_d_r;
  assign sck_fall = cs_s & ~sck_s & sck_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase: fractional accumulator gives a pulse at twice the crystal rate
  logic [ACC_W-1:0] acc_r;
  logic             half_tick_r;
  logic [SUB_W-1:0] sub_cnt_r;
  logic             clk32_r;
  logic             sec_tick_r;
  wire logic [ACC_W-1:0] acc_sum;
  wire logic        acc_over;

  assign acc_sum  = acc_r + ACC_STEP;
  assign acc_over = (acc_sum >= ACC_LIMIT);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_r       <= '0;
      half_tick_r <= 1'b0;
      sub_cnt_r   <= '0;
      clk32_r     <= 1'b0;
      sec_tick_r  <= 1'b0;
    end else begin
      acc_r       <= acc_over ? acc_sum - ACC_LIMIT : acc_sum;
      half_tick_r <= acc_over;
      sec_tick_r  <= half_tick_r && (sub_cnt_r == SUB_LAST);
      if (half_tick_r) begin
        clk32_r   <= ~clk32_r;
        sub_cnt_r <= (sub_cnt_r == SUB_LAST) ? '0 : sub_cnt_r + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine: commands sampled on rising clock, read data driven on falling
  rtcp_state_t      state_r;
  logic [CNT_W-1:0] bit_cnt_r;
  logic [7:0]       shift_r;
  logic [3:0]       idx_r;
  rtcp_wr_t         wr_r;
  logic [7:0]       rd_data;
  wire logic [7:0]  shift_in;
  wire logic [3:0]  cmd_idx;
  wire logic        cmd_rd;
  rtcp_time_t       now;
  logic [2:0]       status2_r;
  logic [5:0]       alarm1_r;
  logic [4:0]       alarm2_r;
  logic [3:0]       freq_r;

  assign shift_in = {shift_r[6:0], din_s};
  assign cmd_idx  = shift_in[CMD_IDX_MSB:CMD_IDX_LSB];
  assign cmd_rd   = shift_in[CMD_RD_BIT];

  always_comb begin
    case (cmd_idx)
      REG_STATUS2: rd_data = {5'h00, status2_r};
      REG_YEAR:    rd_data = {1'b0, now.year};
      REG_MONTH:   rd_data = {4'h0, now.month};
      REG_DAY:     rd_data = {3'h0, now.day};
      REG_HOUR:    rd_data = {3'h0, now.hour};
      REG_MINUTE:  rd_data = {2'h0, now.minute};
      REG_SECOND:  rd_data = {2'h0, now.second};
      REG_ALARM1:  rd_data = {2'h0, alarm1_r};
      REG_ALARM2:  rd_data = {3'h0, alarm2_r};
      REG_FREQ:    rd_data = {4'h0, freq_r};
      default:     rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r           <= ST_IDLE;
      bit_cnt_r         <= '0;
      shift_r           <= 8'h00;
      idx_r             <= 4'h0;
      wr_r              <= '0;
      bidir_data_pin_oe <= 1'b0;
    end else begin
      wr_r.we <= 1'b0;
      if (!cs_s) begin
        state_r           <= ST_IDLE;
        bidir_data_pin_oe <= 1'b0;
      end else if (cs_rise) begin
        state_r           <= ST_CMD;
        bit_cnt_r         <= '0;
        bidir_data_pin_oe <= 1'b0;
      end else begin
        case (state_r)
          ST_CMD: if (sck_rise) begin
            shift_r   <= shift_in;
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == CMD_LAST) begin
              idx_r     <= cmd_idx;
              bit_cnt_r <= '0;
              state_r   <= cmd_rd ? ST_RDATA : ST_WDATA;
              if (cmd_rd) begin
                shift_r <= rd_data;
              end
            end
          end
          ST_WDATA: if (sck_rise) begin
            shift_r   <= shift_in;
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == DATA_LAST) begin
              wr_r    <= '{we: 1'b1, idx: idx_r, data: shift_in};
              state_r <= ST_IDLE;
            end
          end
          ST_RDATA: if (sck_fall) begin
            // Open drain: a one is sent by releasing the line
            bidir_data_pin_oe <= (bit_cnt_r != DATA_DONE) && !shift_r[7];
            if (bit_cnt_r != DATA_DONE) begin
              shift_r   <= {shift_r[6:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
          ST_IDLE:  bidir_data_pin_oe <= 1'b0;
          default:  state_r <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local settings written through the port
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status2_r <= STATUS2_RST;
      alarm1_r  <= ALARM1_RST;
      alarm2_r  <= ALARM2_RST;
      freq_r    <= FREQ_RST;
    end else if (wr_r.we) begin
      case (wr_r.idx)
        REG_STATUS2: status2_r <= wr_r.data[2:0];
        REG_ALARM1:  alarm1_r  <= wr_r.data[5:0];
        REG_ALARM2:  alarm2_r  <= wr_r.data[4:0];
        REG_FREQ:    freq_r    <= wr_r.data[3:0];
        default:     status2_r <= status2_r;
      endcase
    end
  end

  rtcp_calendar u_calendar (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .sec_tick (sec_tick_r),
    .wr       (wr_r),
    .now      (now)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin: active low open drain, so the selected source pulls it low
  wire logic src_alarm1;
  wire logic src_alarm2;
  wire logic src_user;
  wire logic src_min1;
  wire logic src_min2;
  logic      int_sel;

  assign src_alarm1 = (now.minute == alarm1_r);
  assign src_alarm2 = (now.hour == alarm2_r) && (now.minute == '0);
  assign src_user   = sub_cnt_r[freq_r];
  assign src_min1   = (now.second == '0);
  assign src_min2   = (now.second < MINUTE2_HALF);

  always_comb begin
    case (status2_r)
      INT_ALARM1:    int_sel = src_alarm1;
      INT_ALARM2:    int_sel = src_alarm2;
      INT_USER_FREQ: int_sel = src_user;
      INT_MINUTE1:   int_sel = src_min1;
      INT_MINUTE2:   int_sel = src_min2;
      INT_CLK32K:    int_sel = clk32_r;
      default:       int_sel = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_n_oe           <= 1'b0;
      int_n_out          <= 1'b0;
      bidir_data_pin_out <= 1'b0;
    end else begin
      int_n_oe           <= int_sel;
      int_n_out          <= 1'b0;
      bidir_data_pin_out <= 1'b0;
    end
  end

endmodule // rtcp_port
`default_nettype wire

// File: sim/rtcp_port_asserts.sv
// Pin-level assertions of the three-wire calendar clock port
`timescale 1ns/100ps
`default_nettype none
module rtcp_port_asserts
  import rtcp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_pin,
  input wire logic sck_pin,
  input wire logic bidir_data_pin_in,
  input wire logic bidir_data_pin_out,
  input wire logic bidir_data_pin_oe,
  input wire logic int_n_out,
  input wire logic int_n_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  idle_release_a: assert property (!cs_pin [*4] |-> !bidir_data_pin_oe)
    else $error("data line pulled with chip select low");
  cs_rise_input_a: assert property ($rose(cs_pin) |-> ##3 !bidir_data_pin_oe [*8])
    else $error("data line driven during command bits");
  drive_on_fall_a: assert property ($changed(bidir_data_pin_oe) && cs_pin |-> !$past(sck_pin, 3))
    else $error("data line changed away from a clock fall");
  oe_stands_a: assert property ((cs_pin && sck_pin) [*2] |-> $stable(bidir_data_pin_oe))
    else $error("data line changed while serial clock high");
  select_needed_a: assert property ($rose(bidir_data_pin_oe) |-> $past(cs_pin, 60))
    else $error("data line driven without a selected command");
  open_drain_a: assert property (bidir_data_pin_out == 1'b0 && int_n_out == 1'b0)
    else $error("open-drain pin driven high");
  reset_quiet_a: assert property ($fell(rst) |-> !bidir_data_pin_oe && !int_n_oe)
    else $error("outputs active at reset release");
  alarm_default_a: assert property ($fell(rst) |-> ##[1:2] int_n_oe)
    else $error("default alarm source not on the interrupt pin");

  read_cov: cover property ($rose(bidir_data_pin_oe));
  frame_cov: cover property ($fell(cs_pin));
  int_cov: cover property ($rose(int_n_oe));
endmodule // rtcp_port_asserts

bind rtcp_port rtcp_port_asserts i_chk (.ref_clk(ref_clk), .rst(rst), .cs_pin(cs_pin),
  .sck_pin(sck_pin), .bidir_data_pin_in(bidir_data_pin_in),
  .bidir_data_pin_out(bidir_data_pin_out), .bidir_data_pin_oe(bidir_data_pin_oe),
  .int_n_out(int_n_out), .int_n_oe(int_n_oe));
`default_nettype wire

// File: sim/rtcp_host_model.sv
// Host model: chip select, serial clock and its share of the open-drain data wire
`timescale 1ns/100ps
`default_nettype none
module rtcp_host_model
  import rtcp_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic dev_oe,
  output var  logic cs_pin,
  output var  logic sck_pin,
  output wire logic wire_lvl
);
  logic host_oe = 1'b0;
  logic host_bit = 1'b0;

  // Pull-up wins unless either party pulls low
  assign wire_lvl = !(dev_oe || (host_oe && !host_bit));
  initial begin
    cs_pin = 1'b0;
    sck_pin = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge ref_clk);
  endtask

  // n below 16 drops chip select mid-frame
  task automatic xfer(input int n, input logic [7:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    @(negedge ref_clk);
    cs_pin = 1'b1;
    half();
    for (int i = 0; i < n; i++) begin
      host_oe = (i < 8) || !cmd[0];
      host_bit = sh[15 - i];
      half();
      sck_pin = 1'b1;
      repeat (2) @(negedge ref_clk);
      if (i >= 8) rd = {rd[6:0], wire_lvl};
      repeat (2) @(negedge ref_clk);
      sck_pin = 1'b0;
    end
    host_oe = 1'b0;
    half();
    cs_pin = 1'b0;
    half();
    half();
  endtask

  // Clock pulses with chip select low; the zeros would form a write if counted
  task automatic junk(input int n);
    host_oe = 1'b1;
    host_bit = 1'b0;
    repeat (n) begin
      half();
      sck_pin = 1'b1;
      half();
      sck_pin = 1'b0;
    end
    host_oe = 1'b0;
  endtask
endmodule // rtcp_host_model
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench of the calendar clock port
`timescale 1ns/100ps
`default_nettype none
module tb
  import rtcp_pkg::*;
;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       cs_pin;
  logic       sck_pin;
  wire        wire_lvl;
  logic       data_oe;
  logic       data_out;
  logic       int_oe;
  logic       int_out;
  int         bad_count = 0;
  int         cmp_count = 0;
  logic [7:0] rd;
  logic [5:0] mn;
  logic [5:0] sc;
  logic [5:0] al1;
  logic [4:0] hr;
  logic [4:0] al2;
  logic [7:0] rst_tab [10] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
                               8'h00, 8'h0F};

  always #12.5 ref_clk = ~ref_clk;

  rtcp_port i_dut (.ref_clk(ref_clk), .rst(rst), .cs_pin(cs_pin), .sck_pin(sck_pin),
    .bidir_data_pin_in(wire_lvl), .bidir_data_pin_out(data_out),
    .bidir_data_pin_oe(data_oe), .int_n_out(int_out), .int_n_oe(int_oe));
  rtcp_host_model i_host (.ref_clk(ref_clk), .dev_oe(data_oe), .cs_pin(cs_pin),
    .sck_pin(sck_pin), .wire_lvl(wire_lvl));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    i_host.xfer(16, {3'h0, idx, 1'b0}, d, rd);
  endtask
  task automatic rdchk(input string nm, input logic [3:0] idx, input logic [7:0] e);
    i_host.xfer(16, {3'h0, idx, 1'b1}, 8'h00, rd);
    chk(nm, e, rd);
  endtask
  function automatic logic exp_int(input logic [2:0] code);
    case (code)
      INT_ALARM1: return mn == al1;
      INT_ALARM2: return (hr == al2) && (mn == 6'h00);
      INT_MINUTE1: return sc == 6'h00;
      INT_MINUTE2: return sc < MINUTE2_HALF;
      default: return 1'b0;
    endcase
  endfunction
  // Two periods of a 32.768 kHz square give about four transitions
  task automatic toggles(input logic [2:0] code, input int lo, input int hi);
    int   n;
    logic p;
    n = 0;
    wr(REG_STATUS2, {5'h00, code});
    p = int_oe;
    repeat (2442) begin
      @(negedge ref_clk);
      if (int_oe !== p) n++;
      p = int_oe;
    end
    chk("pin toggles", 8'h01, 8'(n >= lo && n <= hi));
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hB25090CA));
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    for (int i = 0; i < 16; i++) rdchk("reg", 4'(i), (i < 10) ? rst_tab[i] : 8'h00);
    wr(4'hC, 8'hA5);
    rdchk("unmapped", 4'hC, 8'h00);
    i_host.xfer(5, 8'h0B, 8'h00, rd);
    rdchk("after abort", REG_FREQ, 8'h0F);
    for (int i = 0; i < 6; i++) begin
      mn = (i == 3) ? 6'h00 : 6'($urandom % 60);
      sc = (i == 0) ? 6'h00 : (i == 1) ? 6'h1D : (i == 2) ? MINUTE2_HALF : 6'($urandom % 60);
      al1 = (i < 2) ? mn : 6'($urandom % 60);
      hr = 5'($urandom % 24);
      al2 = i[0] ? hr : 5'($urandom % 24);
      wr(REG_MINUTE, {2'h0, mn});
      wr(REG_SECOND, {2'h0, sc});
      wr(REG_HOUR, {3'h0, hr});
      wr(REG_ALARM1, {2'h0, al1});
      wr(REG_ALARM2, {3'h0, al2});
      rdchk("minute", REG_MINUTE, {2'h0, mn});
      rdchk("alarm2", REG_ALARM2, {3'h0, al2});
      for (int c = 0; c < 8; c++) begin
        if (c == 2 || c == 5) continue;
        wr(REG_STATUS2, 8'(c));
        chk("int pin", {7'h00, exp_int(3'(c))}, {7'h00, int_oe});
      end
    end
    wr(REG_FREQ, 8'h00);
    toggles(INT_USER_FREQ, 3, 5);
    wr(REG_FREQ, 8'h01);
    toggles(INT_USER_FREQ, 1, 3);
    toggles(INT_CLK32K, 3, 5);
    wr(REG_ALARM1, {2'h0, mn});
    wr(REG_STATUS2, 8'h06);
    i_host.junk(16);
    chk("idle pulses", 8'h00, {7'h00, int_oe});
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    rdchk("status2", REG_STATUS2, 8'h00);
    chk("open drain", 8'h00, {6'h00, data_out, int_out});
    report_and_stop();
  end

  initial begin
    #2ms;
    bad_count++;
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
